/* File: rtl/mpm_pkg.sv */
// shared constants and types of the magnetometer power-mode controller
`default_nettype none
package mpm_pkg;
    localparam int CLK_PERIOD_NS = 50;
    localparam int CLK_HZ = 20_000_000;
    localparam int NS_PER_US = 1000;
    // measurement cycle pieces, in microseconds and in clock cycles
    localparam int PLANAR_REP_TIME_US = 145;
    localparam int Z_REP_TIME_US = 500;
    localparam int BASE_TIME_US = 980;
    localparam int PLANAR_REP_CYCLES = PLANAR_REP_TIME_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int Z_REP_CYCLES = Z_REP_TIME_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int BASE_CYCLES = BASE_TIME_US * NS_PER_US / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam int REP_W = 9;
    localparam int PER_W = 24;
    localparam int ODR_NUM = 8;
    localparam int ODR_W = 3;
    localparam int ODR_HZ [ODR_NUM] = '{10, 2, 6, 8, 15, 20, 25, 30};
    // register offsets
    localparam logic [7:0] ADDR_ID = 8'h40;
    localparam logic [7:0] ADDR_PWR = 8'h4B;
    localparam logic [7:0] ADDR_OPM = 8'h4C;
    localparam logic [7:0] ADDR_XYREP = 8'h51;
    localparam logic [7:0] ADDR_ZREP = 8'h52;
    // field positions and mode field codes
    localparam int PWR_BIT = 0;
    localparam int THREE_WIRE_BIT = 2;
    localparam int SRST_BIT = 7;
    localparam int OPM_LSB = 1;
    localparam int ODR_LSB = 3;
    localparam logic [1:0] OPM_NORMAL = 2'h0;
    localparam logic [1:0] OPM_FORCED = 2'h1;
    localparam logic [1:0] OPM_SLEEP = 2'h3;
    // reset values, blank read value and power store mask
    localparam logic [7:0] PWR_RST = 8'h00;
    localparam logic [7:0] OPM_RST = 8'h06;
    localparam logic [7:0] REP_RST = 8'h00;
    localparam logic [7:0] READ_BLANK = 8'h00;
    localparam logic [7:0] PWR_STORE_MASK = 8'h05;
    typedef enum logic [2:0] {
        MPM_OFF, MPM_POR, MPM_STARTUP, MPM_SUSPEND, MPM_SLEEP, MPM_NORMAL, MPM_FORCED
    } mpm_mode_type;
endpackage
`default_nettype wire

/* File: rtl/mpm_cycle_if.sv */
// link between the mode controller and the measurement cycle timer
`timescale 1ns/1ps
`default_nettype none
interface mpm_cycle_if;
    import mpm_pkg::*;
    logic start;
    logic abort;
    logic [REP_W-1:0] planar_repetitions;
    logic [REP_W-1:0] vertical_repetitions;
    logic busy;
    logic done;
    modport ctrl (output start, abort, planar_repetitions, vertical_repetitions, input busy, done);
    modport timer (input start, abort, planar_repetitions, vertical_repetitions, output busy, done);
endinterface
`default_nettype wire

/* File: rtl/mpm_sync.sv */
// two-flop synchronisers for the asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module mpm_sync #(
    parameter int W = 3
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [W-1:0] d_async,
    output logic [W-1:0] q
);
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        logic meta_reg;
        logic sync_reg;
        always_ff @(posedge clock)
        begin
            if (sys_rst)
            begin
                meta_reg <= 1'b0;
                sync_reg <= 1'b0;
            end
            else
            begin
                meta_reg <= d_async[i];
                sync_reg <= meta_reg;
            end
        end
        assign q[i] = sync_reg;
    end
endmodule // mpm_sync
`default_nettype wire

/* File: rtl/mpm_cycle_timer.sv */
// measurement cycle timer: length from the repetition counts
`timescale 1ns/1ps
`default_nettype none
module mpm_cycle_timer #(
    parameter int CNT_W = mpm_pkg::CNT_W,
    parameter int Z_CYC = mpm_pkg::Z_REP_CYCLES,
    parameter int BASE_CYC = mpm_pkg::BASE_CYCLES
) (
    input wire logic clock,
    input wire logic sys_rst,
    mpm_cycle_if.timer c
);
    import mpm_pkg::*;
    logic [CNT_W-1:0] total;
    logic [CNT_W-1:0] cnt_reg;
    logic busy_reg;
    logic done_reg;
    // the whole length is loaded at once; no per-axis sequencing is needed here
    assign total = CNT_W'(PLANAR_REP_CYCLES) * CNT_W'(c.planar_repetitions)
        + CNT_W'(Z_CYC) * CNT_W'(c.vertical_repetitions) + CNT_W'(BASE_CYC); // R17
    always_ff @(posedge clock)
    begin
        if (sys_rst || c.abort)
        begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
        end
        else if (c.start)
        begin
            busy_reg <= 1'b1; // R16
            cnt_reg <= total;
        end
        else if (busy_reg)
        begin
            cnt_reg <= cnt_reg - CNT_W'(1);
            if (cnt_reg == CNT_W'(1))
                busy_reg <= 1'b0;
        end
    end
    always_ff @(posedge clock)
    begin
        if (sys_rst)
            done_reg <= 1'b0;
        else
            done_reg <= busy_reg && cnt_reg == CNT_W'(1) && !c.start && !c.abort; // R16
    end
    assign c.busy = busy_reg;
    assign c.done = done_reg;

    length_a: assert property (@(posedge clock) disable iff (sys_rst) // R17
        c.start && !c.abort |=> busy_reg && cnt_reg == $past(total))
        else $error("cycle length not loaded from repetition counts");
    done_end_a: assert property (@(posedge clock) disable iff (sys_rst) // R17
        done_reg |-> !busy_reg && $past(busy_reg) && $past(cnt_reg) == CNT_W'(1))
        else $error("cycle done without full count");
endmodule // mpm_cycle_timer
`default_nettype wire

/* File: rtl/mpm_power_ctrl.sv */
// power-mode controller of a three-axis magnetic sensor
//
// What the document requires
// R1: power off until both supplies valid
// R2: power-on reset restores all register defaults
// R3: start-up loads nonvolatile store before modes
// R4: suspend mode entered after start-up
// R5: suspend allows only power control register
// R6: entering suspend clears all but power control
// R7: suspended id read: zero or undriven line
// R8: power bit one moves suspend to sleep
// R9: mode field 11 returns active to sleep
// R10: sleep gives full register access
// R11: power bit zero moves to suspend
// R12: active mode field setting leaves sleep
// R13: normal mode measures once per rate period (code skips a period that ends while a cycle still runs)
// R14: soft reset in normal returns to sleep
// R15: forced measures once then sets field 11
// R16: retrigger discards unfinished result
// R17: cycle length from repetitions plus base
// R18: host spaces forced triggers by cycle length
// R19: host should use standard repetition presets
// R20: results loaded together after all axes
// R21: field 00 normal, 01 forced, 11 sleep
`timescale 1ns/1ps
`default_nettype none
module mpm_power_ctrl #(
    parameter logic [7:0] ID_CODE = 8'hA5, // arbitrary value
    parameter int Z_CYC = mpm_pkg::Z_REP_CYCLES,
    parameter int BASE_CYC = mpm_pkg::BASE_CYCLES,
    parameter int ODR_BASE_CYC = mpm_pkg::CLK_HZ
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic vdd_ok,
    input wire logic vddio_ok,
    input wire logic protocol_select_pin,
    input wire logic nvm_load_done,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic reg_ack,
    output logic [7:0] reg_rdata,
    output logic reg_rdata_oe,
    output logic nvm_load_start,
    output logic data_load,
    output logic three_wire_serial_enable,
    output var mpm_pkg::mpm_mode_type power_mode
);
    import mpm_pkg::*;

    logic [2:0] pin_sync;
    logic supplies_ok;
    logic proto_i2c;
    mpm_mode_type state_reg;
    mpm_mode_type state_next;
    logic [7:0] pwr_reg;
    logic [7:0] opm_reg;
    logic [7:0] xyrep_reg;
    logic [7:0] zrep_reg;
    logic [PER_W-1:0] per_cnt_reg;
    logic [PER_W-1:0] odr_cyc [ODR_NUM];
    logic acc_ok;
    logic wr_pwr;
    logic wr_opm;
    logic rd_req;
    logic pwr_on;
    logic soft_rst;
    logic period_tick;
    logic active_next;
    logic [1:0] opm_val;

    mpm_cycle_if cyc ();

    mpm_sync #(.W(3)) u_sync (
        .clock(clock),
        .sys_rst(sys_rst),
        .d_async({protocol_select_pin, vddio_ok, vdd_ok}),
        .q(pin_sync)
    );

    mpm_cycle_timer #(.CNT_W(CNT_W), .Z_CYC(Z_CYC), .BASE_CYC(BASE_CYC)) u_timer (
        .clock(clock),
        .sys_rst(sys_rst),
        .c(cyc.timer)
    );

    assign supplies_ok = pin_sync[0] & pin_sync[1];
    // protocol select pin high means I2C
    assign proto_i2c = pin_sync[2];

    ////////////////////////////////////////////////////////////////////////////
    // access decode
    always_comb
    begin
        unique case (state_reg)
            MPM_SUSPEND: acc_ok = (reg_addr == ADDR_PWR); // R5
            MPM_SLEEP, MPM_NORMAL, MPM_FORCED: acc_ok = 1'b1; // R10 R12
            default: acc_ok = 1'b0;
        endcase
    end

    assign wr_pwr = reg_req && reg_write && acc_ok && reg_addr == ADDR_PWR;
    assign wr_opm = reg_req && reg_write && acc_ok && reg_addr == ADDR_OPM;
    assign rd_req = reg_req && !reg_write;
    assign pwr_on = reg_wdata[PWR_BIT];
    assign soft_rst = wr_pwr && reg_wdata[SRST_BIT];
    assign opm_val = reg_wdata[OPM_LSB +: 2];

    ////////////////////////////////////////////////////////////////////////////
    // power mode sequence
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            MPM_OFF:
                if (supplies_ok)
                    state_next = MPM_POR; // R1
            MPM_POR:
                state_next = MPM_STARTUP; // R3
            MPM_STARTUP:
                if (nvm_load_done)
                    state_next = MPM_SUSPEND; // R4
            MPM_SUSPEND:
                if (wr_pwr && pwr_on)
                    state_next = MPM_SLEEP; // R8
            MPM_SLEEP:
            begin
                if (wr_pwr && !pwr_on)
                    state_next = MPM_SUSPEND; // R11
                else if (wr_opm && opm_val == OPM_NORMAL)
                    state_next = MPM_NORMAL; // R12 R21
                else if (wr_opm && opm_val == OPM_FORCED)
                    state_next = MPM_FORCED; // R12 R21
            end
            MPM_NORMAL, MPM_FORCED:
            begin
                if (wr_pwr && !pwr_on)
                    state_next = MPM_SUSPEND; // R11
                else if (soft_rst || (wr_opm && opm_val == OPM_SLEEP))
                    state_next = MPM_SLEEP; // R9 R14
                else if (wr_opm && opm_val == OPM_NORMAL)
                    state_next = MPM_NORMAL;
                else if (wr_opm && opm_val == OPM_FORCED)
                    state_next = MPM_FORCED;
                else if (state_reg == MPM_FORCED && cyc.done)
                    state_next = MPM_SLEEP; // R15
            end
            default:
                state_next = MPM_OFF;
        endcase
        // a lost supply wins over everything
        if (!supplies_ok)
            state_next = MPM_OFF; // R1
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            state_reg <= MPM_OFF;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            nvm_load_start <= 1'b0;
        else
            nvm_load_start <= state_reg == MPM_POR && state_next == MPM_STARTUP; // R3
    end

    assign power_mode = state_reg;

    ////////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge clock)
    begin
        if (sys_rst || state_reg == MPM_OFF || state_reg == MPM_POR)
        begin
            pwr_reg <= PWR_RST; // R2
            opm_reg <= OPM_RST;
            xyrep_reg <= REP_RST;
            zrep_reg <= REP_RST;
        end
        else
        begin
            // soft reset bit is not stored, so it always reads back zero
            if (wr_pwr)
                pwr_reg <= reg_wdata & PWR_STORE_MASK;
            if (soft_rst || (state_next == MPM_SUSPEND && state_reg != MPM_SUSPEND))
            begin
                opm_reg <= OPM_RST; // R6 R14
                xyrep_reg <= REP_RST;
                zrep_reg <= REP_RST;
            end
            else
            begin
                if (wr_opm)
                    opm_reg <= reg_wdata;
                else if (state_reg == MPM_FORCED && state_next == MPM_SLEEP)
                    opm_reg[OPM_LSB +: 2] <= OPM_SLEEP; // R15
                if (reg_req && reg_write && acc_ok && reg_addr == ADDR_XYREP)
                    xyrep_reg <= reg_wdata;
                if (reg_req && reg_write && acc_ok && reg_addr == ADDR_ZREP)
                    zrep_reg <= reg_wdata;
            end
        end
    end

    assign three_wire_serial_enable = pwr_reg[THREE_WIRE_BIT];

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_ack <= 1'b0;
            reg_rdata <= READ_BLANK;
            reg_rdata_oe <= 1'b0;
        end
        else
        begin
            reg_ack <= reg_req;
            if (rd_req)
            begin
                // on SPI a blocked read leaves the data line undriven
                reg_rdata_oe <= acc_ok || proto_i2c; // R7
                if (!acc_ok)
                    reg_rdata <= READ_BLANK; // R5 R7
                else
                begin
                    case (reg_addr)
                        ADDR_ID: reg_rdata <= ID_CODE; // R10
                        ADDR_PWR: reg_rdata <= pwr_reg;
                        ADDR_OPM: reg_rdata <= opm_reg;
                        ADDR_XYREP: reg_rdata <= xyrep_reg;
                        ADDR_ZREP: reg_rdata <= zrep_reg;
                        default: reg_rdata <= READ_BLANK;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // measurement scheduling
    for (genvar i = 0; i < ODR_NUM; i++)
    begin : g_odr
        assign odr_cyc[i] = PER_W'(ODR_BASE_CYC / ODR_HZ[i]);
    end

    // first period starts in the first normal-mode cycle
    assign period_tick = state_reg == MPM_NORMAL && per_cnt_reg == '0;

    always_ff @(posedge clock)
    begin
        if (sys_rst || state_reg != MPM_NORMAL)
            per_cnt_reg <= '0;
        else if (period_tick)
            per_cnt_reg <= odr_cyc[opm_reg[ODR_LSB +: ODR_W]] - PER_W'(1); // R13
        else
            per_cnt_reg <= per_cnt_reg - PER_W'(1);
    end

    assign active_next = state_next == MPM_NORMAL || state_next == MPM_FORCED;
    // a period that ends while a cycle still runs is skipped, not queued
    assign cyc.start = (wr_opm && opm_val == OPM_FORCED && state_next == MPM_FORCED)
        || (period_tick && !cyc.busy && state_next == MPM_NORMAL); // R13 R16 R21
    assign cyc.abort = !active_next; // R16
    assign cyc.planar_repetitions = {xyrep_reg, 1'b1};
    assign cyc.vertical_repetitions = {1'b0, zrep_reg} + REP_W'(1);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            data_load <= 1'b0;
        else
            data_load <= cyc.done; // R20
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    off_hold_a: assert property (!supplies_ok |=> state_reg == MPM_OFF) // R1
        else $error("left power off without valid supplies");
    por_clear_a: assert property (state_reg == MPM_POR |=> pwr_reg == PWR_RST // R2
        && opm_reg == OPM_RST && xyrep_reg == REP_RST && zrep_reg == REP_RST)
        else $error("registers not at defaults after power-on reset");
    nvm_first_a: assert property (state_reg == MPM_POR && supplies_ok // R3
        |=> state_reg == MPM_STARTUP && nvm_load_start ##1 !nvm_load_start)
        else $error("start-up load not requested once after reset");
    boot_suspend_a: assert property (state_reg == MPM_STARTUP && nvm_load_done // R4
        && supplies_ok |=> state_reg == MPM_SUSPEND)
        else $error("start-up did not end in suspend");
    suspend_block_a: assert property (state_reg == MPM_SUSPEND && reg_req // R5
        && reg_addr != ADDR_PWR |=> $stable(opm_reg) && $stable(xyrep_reg))
        else $error("register changed by access in suspend");
    suspend_keep_a: assert property (state_reg inside {MPM_SLEEP, MPM_NORMAL} // R6
        && state_next == MPM_SUSPEND |=> opm_reg == OPM_RST && zrep_reg == REP_RST)
        else $error("registers kept on entering suspend");
    id_blank_a: assert property (state_reg == MPM_SUSPEND && rd_req // R7
        && reg_addr == ADDR_ID |=> reg_rdata == READ_BLANK && reg_rdata_oe == $past(proto_i2c))
        else $error("suspended identification read not blank");
    wake_sleep_a: assert property (state_reg == MPM_SUSPEND && wr_pwr && pwr_on // R8
        && supplies_ok |=> state_reg == MPM_SLEEP)
        else $error("power bit did not wake to sleep");
    back_sleep_a: assert property (state_reg inside {MPM_NORMAL, MPM_FORCED} && wr_opm // R9
        && opm_val == OPM_SLEEP && supplies_ok |=> state_reg == MPM_SLEEP && !cyc.busy)
        else $error("mode field 11 did not return to sleep");
    id_read_a: assert property (state_reg == MPM_SLEEP && rd_req // R10
        && reg_addr == ADDR_ID |=> reg_rdata == ID_CODE && reg_rdata_oe)
        else $error("identification not readable in sleep");
    to_suspend_a: assert property (state_reg inside {MPM_SLEEP, MPM_NORMAL} && wr_pwr // R11
        && !pwr_on && supplies_ok |=> state_reg == MPM_SUSPEND)
        else $error("power bit zero did not suspend");
    forced_go_a: assert property (state_reg == MPM_SLEEP && wr_opm // R12
        && opm_val == OPM_FORCED && supplies_ok |=> state_reg == MPM_FORCED && cyc.busy)
        else $error("forced write did not start a cycle");
    period_a: assert property (period_tick && !cyc.busy // R13
        && state_next == MPM_NORMAL |=> cyc.busy && per_cnt_reg != '0)
        else $error("normal period did not start a cycle");
    soft_sleep_a: assert property (state_reg == MPM_NORMAL && soft_rst && pwr_on // R14
        && supplies_ok |=> state_reg == MPM_SLEEP && opm_reg == OPM_RST)
        else $error("soft reset did not return to sleep");
    forced_end_a: assert property (state_reg == MPM_FORCED && cyc.done && !reg_req // R15
        && supplies_ok |=> state_reg == MPM_SLEEP && data_load
        && opm_reg[OPM_LSB +: 2] == OPM_SLEEP)
        else $error("forced cycle end mishandled");
    discard_a: assert property (cyc.start && cyc.busy |=> cyc.busy && !data_load) // R16
        else $error("interrupted cycle result loaded");
    load_done_a: assert property (data_load |-> $past(cyc.done)) // R20
        else $error("data loaded without a finished cycle");
endmodule // mpm_power_ctrl
`default_nettype wire

/* File: tb/mpm_host_model.sv */
// host-side model that issues single-byte register requests
`timescale 1ns/1ps
`default_nettype none
module mpm_host_model (
    input wire logic clock,
    input wire logic reg_ack,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rdata_oe,
    output logic reg_req,
    output logic reg_write,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    time taken_t;
    logic ack_seen;
    initial
    begin
        reg_req = 1'b0;
        reg_write = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        taken_t = 0;
        ack_seen = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // idle lines carry the inverse so a stale request never looks valid
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata, output logic oe);
        @(posedge clock);
        reg_req <= 1'b1;
        reg_write <= wr;
        reg_addr <= addr;
        reg_wdata <= wdata;
        @(posedge clock);
        taken_t = $time;
        reg_req <= 1'b0;
        reg_write <= ~wr;
        reg_addr <= ~addr;
        reg_wdata <= ~wdata;
        @(posedge clock);
        ack_seen = reg_ack;
        rdata = reg_rdata;
        oe = reg_rdata_oe;
    endtask
endmodule // mpm_host_model
`default_nettype wire

/* File: tb/mpm_power_ctrl_bench.sv */
// self-checking bench of the power-mode controller
`timescale 1ns/1ps
`default_nettype none
`define MPM_CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module mpm_power_ctrl_bench;
    import mpm_pkg::*;
    localparam logic [7:0] ID = 8'h3C; // arbitrary value
    localparam int T_MIN = 2900 + 4 + 8;
    localparam int T_LP = 2900 * 3 + 4 * 3 + 8;
    logic clock, sys_rst, vdd_ok, vddio_ok, protocol_select_pin, nvm_load_done;
    logic reg_req, reg_write, reg_ack, reg_rdata_oe, nvm_load_start, data_load;
    logic three_wire_serial_enable, rd_oe;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_byte;
    mpm_mode_type power_mode;
    int errors = 0;
    int comparisons = 0;
    int loads = 0;
    int nvm_starts = 0;
    int base, load_cyc;
    initial clock = 1'b0;
    always #25 clock = ~clock;
    mpm_power_ctrl #(.ID_CODE(ID), .Z_CYC(4), .BASE_CYC(8), .ODR_BASE_CYC(200)) i_dut (
        .clock(clock), .sys_rst(sys_rst), .vdd_ok(vdd_ok), .vddio_ok(vddio_ok),
        .protocol_select_pin(protocol_select_pin), .nvm_load_done(nvm_load_done),
        .reg_req(reg_req), .reg_write(reg_write), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .reg_rdata_oe(reg_rdata_oe), .nvm_load_start(nvm_load_start),
        .data_load(data_load), .three_wire_serial_enable(three_wire_serial_enable),
        .power_mode(power_mode));
    mpm_host_model i_host (.clock(clock), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
        .reg_rdata_oe(reg_rdata_oe), .reg_req(reg_req), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    always @(posedge clock)
    begin
        if (data_load === 1'b1) loads <= loads + 1;
        if (nvm_load_start === 1'b1) nvm_starts <= nvm_starts + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
        begin
            $display("Test passed");
        end
        else
        begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp, input logic exp_oe);
        i_host.xfer(1'b0, addr, 8'h00, rd_byte, rd_oe);
        `MPM_CHECK(i_host.ack_seen, 1'b1)
        `MPM_CHECK(rd_byte, exp)
        `MPM_CHECK(rd_oe, exp_oe)
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_host.xfer(1'b1, addr, data, rd_byte, rd_oe);
        `MPM_CHECK(i_host.ack_seen, 1'b1)
    endtask
    task automatic wait_mode(input mpm_mode_type m, input int n);
        for (int i = 0; i < n && power_mode !== m; i++) @(posedge clock);
        `MPM_CHECK(power_mode, m)
    endtask
    // load_cyc counts edges from the taking edge of the last request to the edge
    // that first samples the pulse, one past the edge that launches it
    task automatic wait_load(input int n);
        logic found;
        found = 1'b0;
        for (int i = 0; i < n && !found; i++)
        begin
            @(posedge clock);
            found = (data_load === 1'b1);
        end
        load_cyc = int'(($time - i_host.taken_t) / CLK_PERIOD_NS);
        `MPM_CHECK(found, 1'b1)
    endtask
    task automatic boot;
        wait_mode(MPM_STARTUP, 10);
        nvm_load_done <= 1'b1;
        @(posedge clock);
        nvm_load_done <= 1'b0;
        wait_mode(MPM_SUSPEND, 5);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (60000) @(posedge clock);
        errors++;
        $display("watchdog expired at %0t", $time);
        report_and_stop();
    end
    initial
    begin
        sys_rst = 1'b1;
        vdd_ok = 1'b1;
        vddio_ok = 1'b0;
        protocol_select_pin = 1'b1;
        nvm_load_done = 1'b0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clock);
        `MPM_CHECK(power_mode, MPM_OFF)
        vddio_ok <= 1'b1;
        wait_mode(MPM_STARTUP, 10);
        repeat (8) @(posedge clock);
        `MPM_CHECK(power_mode, MPM_STARTUP)
        `MPM_CHECK(nvm_starts, 1)
        boot();
        $display("test power-up done");
        rd(ADDR_ID, READ_BLANK, 1'b1);
        wr(ADDR_OPM, 8'h00);
        `MPM_CHECK(power_mode, MPM_SUSPEND)
        protocol_select_pin <= 1'b0;
        repeat (4) @(posedge clock);
        rd(ADDR_ID, READ_BLANK, 1'b0);
        protocol_select_pin <= 1'b1;
        repeat (4) @(posedge clock);
        wr(ADDR_PWR, 8'h05);
        `MPM_CHECK(power_mode, MPM_SLEEP)
        `MPM_CHECK(three_wire_serial_enable, 1'b1)
        rd(ADDR_OPM, OPM_RST, 1'b1);
        rd(ADDR_ID, ID, 1'b1);
        wr(ADDR_XYREP, 8'h01);
        rd(ADDR_XYREP, 8'h01, 1'b1);
        wr(ADDR_PWR, 8'h04);
        `MPM_CHECK(power_mode, MPM_SUSPEND)
        `MPM_CHECK(three_wire_serial_enable, 1'b1)
        wr(ADDR_PWR, 8'h05);
        rd(ADDR_XYREP, REP_RST, 1'b1);
        rd(ADDR_PWR, 8'h05, 1'b1);
        $display("test suspend and sleep done");
        // low power preset: codes 1 and 2 give three repetitions each
        wr(ADDR_XYREP, 8'h01);
        wr(ADDR_ZREP, 8'h02);
        base = loads;
        wr(ADDR_OPM, 8'h02);
        `MPM_CHECK(power_mode, MPM_FORCED)
        wait_load(T_LP + 20);
        `MPM_CHECK(load_cyc, T_LP + 2)
        `MPM_CHECK(power_mode, MPM_SLEEP)
        rd(ADDR_OPM, 8'h06, 1'b1);
        `MPM_CHECK(loads, base + 1)
        base = loads;
        wr(ADDR_OPM, 8'h02);
        repeat (100) @(posedge clock);
        wr(ADDR_OPM, 8'h02);
        wait_load(T_LP + 20);
        `MPM_CHECK(load_cyc, T_LP + 2)
        repeat (2) @(posedge clock);
        `MPM_CHECK(loads, base + 1)
        $display("test forced done");
        // normal mode: a period that ends while the cycle still runs is skipped, not queued
        wr(ADDR_XYREP, 8'h00);
        wr(ADDR_ZREP, 8'h00);
        wr(ADDR_OPM, 8'h00);
        `MPM_CHECK(power_mode, MPM_NORMAL)
        wait_load(T_MIN + 30);
        wait_load(T_MIN + 30);
        `MPM_CHECK(power_mode, MPM_NORMAL)
        rd(ADDR_ID, ID, 1'b1);
        wr(ADDR_OPM, 8'h06);
        `MPM_CHECK(power_mode, MPM_SLEEP)
        base = loads;
        repeat (T_MIN + 50) @(posedge clock);
        `MPM_CHECK(loads, base)
        wr(ADDR_OPM, 8'h00);
        wr(ADDR_PWR, 8'h85);
        `MPM_CHECK(power_mode, MPM_SLEEP)
        rd(ADDR_OPM, OPM_RST, 1'b1);
        rd(ADDR_PWR, 8'h05, 1'b1);
        wr(ADDR_OPM, 8'h00);
        wr(ADDR_PWR, 8'h04);
        `MPM_CHECK(power_mode, MPM_SUSPEND)
        $display("test normal done");
        vdd_ok <= 1'b0;
        wait_mode(MPM_OFF, 6);
        vdd_ok <= 1'b1;
        boot();
        rd(ADDR_PWR, PWR_RST, 1'b1);
        `MPM_CHECK(three_wire_serial_enable, 1'b0)
        $display("test supply loss done");
        report_and_stop();
    end
endmodule // mpm_power_ctrl_bench
`default_nettype wire
